/* File: logic/charge_seq_pkg.sv */
package charge_seq_pkg;

   // timing
   localparam int unsigned CLK_HZ            = 100_000_000;
   localparam int unsigned TICK_PERIOD_MS    = 1;
   localparam int unsigned TICK_CYCLES       = CLK_HZ / 1000 * TICK_PERIOD_MS;
   localparam int unsigned DEAD_BATT_MIN     = 30;
   localparam int unsigned DEAD_BATT_TICKS   = DEAD_BATT_MIN * 60 * 1000 / TICK_PERIOD_MS;
   localparam int unsigned TOTAL_HOURS_BASE  = 5;
   localparam int unsigned TICKS_PER_HOUR    = 60 * 60 * 1000 / TICK_PERIOD_MS;
   localparam int unsigned SOFT_STEP_TICKS   = 1;
   localparam int unsigned RESTART_DEB_MS    = 60;
   localparam int unsigned RESTART_DEB_TICKS = RESTART_DEB_MS / TICK_PERIOD_MS;
   localparam int unsigned TIMER_W           = 32;

   // current codes (ma units for the analog loop)
   localparam int unsigned CUR_W             = 10;
   localparam logic [9:0]  CUR_PRECHARGE_MA  = 10'h05a;
   localparam logic [9:0]  CUR_STEP_MA       = 10'h032;

   // register-like reset values
   localparam logic [2:0]  FC_SETTING_RESET  = 3'h3;
   localparam logic [1:0]  TC_DURATION_RESET = 2'h0;
   localparam logic        DBT_EN_RESET      = 1'b1;
   localparam logic        TCT_EN_RESET      = 1'b1;

   // accessory classes
   typedef enum logic [2:0] {
      ACC_NONE, ACC_SDP, ACC_CDP, ACC_DCP, ACC_CARKIT, ACC_TRAVEL
   } accessory_t;

   // fast-charge setting code to milliamps: 90 + 120*code, cast to 10 bits
   function automatic logic [9:0] fc_code_ma(input logic [2:0] code);
      fc_code_ma = 10'(90 + 120 * int'(code));
   endfunction

endpackage

/* File: logic/sync_two_ff.sv */
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff #(
   parameter int W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] q_reg;
   logic [W-1:0] q_next;

   always_comb begin
      meta_next = d;
      q_next    = meta_reg;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         meta_reg <= '0;
         q_reg    <= '0;
      end else begin
         meta_reg <= meta_next;
         q_reg    <= q_next;
      end
   end

   assign q = q_reg;
endmodule // sync_two_ff
`default_nettype wire

/* File: logic/battery_charge_sequencer.sv */
// Overview of operation
// R01: with a valid supply and the battery below the pre-qualification level, trickle at 90 mA.
// R02: on first supply valid, start the total timer and the dead-battery timer if enabled.
// R03: after reset the dead-battery timer is enabled, total timer enabled at five hours.
// R04: a dead-battery timer that runs out while the battery is still low shuts the charger off.
// R05: removing and reattaching the source restarts a full dead-battery period.
// R06: in pre-qualification detection and the serial bus are held off while charging goes on.
// R07: above the pre-qualification level enter fast charge with the programmed current.
// R08: the fast-charge current setting resets to the 450 mA code.
// R09: the fast-charge current ramps up in steps rather than jumping.
// R10: with only a standard downstream port detected, fast charge uses 90 mA.
// R11: force picks the setting, auto-select picks it for CDP, DCP or car kit, else 90 mA.
// R12: in fast charge the source is classified from the data lines and the id resistance.
// R13: at the regulation voltage enter voltage regulation, then halt or top off at termination.
// R14: a total timer overrun before termination stops charging until the charger is re-enabled.
// R15: with top-off off and auto-stop on, restart fast charge when the battery drops the margin.
// R16: comparator inputs are synchronised and long timers count a prescaled tick.
// R17: loss of supply returns to idle with the charger off and timers cleared.
`timescale 1ns/1ps
`default_nettype none
module battery_charge_sequencer
   import charge_seq_pkg::*;
#(
   parameter int unsigned TICK_DIV       = TICK_CYCLES,
   parameter int unsigned DEAD_TICKS     = DEAD_BATT_TICKS,
   parameter int unsigned HOUR_TICKS     = TICKS_PER_HOUR,
   parameter int unsigned TOPOFF_TICKS   = DEAD_BATT_TICKS,
   parameter int unsigned DEBOUNCE_TICKS = RESTART_DEB_TICKS
) (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       supply_valid,
   input  wire logic       batt_above_prequal,
   input  wire logic       batt_at_regulation,
   input  wire logic       batt_below_restart,
   input  wire logic       term_current_reached,
   input  wire logic       connector_data_plus,
   input  wire logic       connector_data_minus,
   input  wire logic       data_lines_shorted,
   input  wire logic       host_port_present,
   input  wire logic       charging_port_signature,
   input  wire logic [4:0] accessory_id_line,
   input  wire logic       charger_enable,
   input  wire logic       dead_battery_timer_enable,
   input  wire logic       total_charge_timer_enable,
   input  wire logic [1:0] total_charge_duration_select,
   input  wire logic [2:0] fast_charge_current_setting,
   input  wire logic       fast_charge_force,
   input  wire logic       fast_charge_auto_select,
   input  wire logic       topoff_enable,
   input  wire logic       auto_stop,
   output logic            charger_on,
   output logic [9:0]      charge_current_ma,
   output logic            voltage_loop_active,
   output logic            detection_enable,
   output logic            serial_bus_enable,
   output logic [2:0]      accessory_type,
   output logic [2:0]      charge_stage,
   output logic            dead_battery_fault,
   output logic            total_timer_fault
);

   // R03 R08 config reset values
   // the outside register block resets these pins to DBT_EN_RESET, TCT_EN_RESET,
   // TC_DURATION_RESET and FC_SETTING_RESET from the package

   typedef enum logic [2:0] {
      ST_IDLE, ST_PRECHARGE, ST_FAST, ST_VREG, ST_TOPOFF, ST_DONE, ST_FAULT
   } stage_t;

   //////////////////////////////////////////////////////////////////////////////
   // input synchronisers
   localparam int NSYNC = 15;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] syn;
   logic             sv_s, above_s, atreg_s, below_s, term_s, dp_s, dm_s, short_s;
   logic             host_s, cport_s;
   logic [4:0]       id_s;

   assign raw_in = {supply_valid, batt_above_prequal, batt_at_regulation,
                    batt_below_restart, term_current_reached, connector_data_plus,
                    connector_data_minus, data_lines_shorted, host_port_present,
                    charging_port_signature, accessory_id_line};

   // R16 synchronised comparators
   sync_two_ff #(.W(NSYNC)) u_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .d       (raw_in),
      .q       (syn)
   );
   assign {sv_s, above_s, atreg_s, below_s, term_s, dp_s, dm_s, short_s,
           host_s, cport_s, id_s} = syn;

   //////////////////////////////////////////////////////////////////////////////
   // state
   stage_t          stage_reg, stage_next;
   logic [31:0]     pre_reg, pre_next;
   logic            tick;
   logic [31:0]     dead_reg, dead_next;
   logic [31:0]     total_reg, total_next;
   logic [31:0]     aux_reg, aux_next;
   logic            dead_run_reg, dead_run_next;
   logic            sv_d_reg, sv_d_next;
   logic            en_d_reg, en_d_next;
   logic [9:0]      cur_reg, cur_next;
   logic [9:0]      target;
   accessory_t      acc_reg, acc_next;
   logic            dfault_reg, dfault_next;
   logic            tfault_reg, tfault_next;
   logic [31:0]     total_limit;

   // R12 classify source
   function automatic accessory_t classify(input logic shorted, input logic host,
                                           input logic cport, input logic [4:0] id);
      if (id == 5'h17)
         classify = ACC_CARKIT;
      else if (id == 5'h16)
         classify = ACC_TRAVEL;
      else if (shorted)
         classify = ACC_DCP;
      else if (host && cport)
         classify = ACC_CDP;
      else if (host)
         classify = ACC_SDP;
      else
         classify = ACC_NONE;
   endfunction

   assign total_limit = HOUR_TICKS * (TOTAL_HOURS_BASE + 32'(total_charge_duration_select));

   always_comb begin
      // R16 prescaled tick
      tick     = (pre_reg == TICK_DIV - 1);
      pre_next = tick ? 32'h0 : pre_reg + 32'h1;

      // R11 fast-charge current selection
      if (fast_charge_force)
         target = fc_code_ma(fast_charge_current_setting);
      else if (fast_charge_auto_select &&
               (acc_reg == ACC_CDP || acc_reg == ACC_DCP || acc_reg == ACC_CARKIT))
         target = fc_code_ma(fast_charge_current_setting);
      else
         // R10 sdp falls back to precharge level
         target = CUR_PRECHARGE_MA;

      stage_next    = stage_reg;
      dead_next     = dead_reg;
      total_next    = total_reg;
      aux_next      = aux_reg;
      dead_run_next = dead_run_reg;
      sv_d_next     = sv_s;
      en_d_next     = charger_enable;
      cur_next      = cur_reg;
      acc_next      = acc_reg;
      dfault_next   = dfault_reg;
      tfault_next   = tfault_reg;

      // total timer runs in charging stages before termination
      if (tick && total_charge_timer_enable &&
          (stage_reg == ST_PRECHARGE || stage_reg == ST_FAST || stage_reg == ST_VREG))
         total_next = total_reg + 32'h1;
      // R04 dead-battery timer counts while the battery stays low
      if (tick && dead_run_reg && dead_battery_timer_enable)
         dead_next = dead_reg + 32'h1;

      case (stage_reg)
         ST_IDLE: begin
            cur_next = 10'h0;
            if (sv_s && !sv_d_reg) begin
               // R02 R05 fresh timers on attach
               dead_next     = 32'h0;
               total_next    = 32'h0;
               dead_run_next = dead_battery_timer_enable;
               dfault_next   = 1'b0;
               tfault_next   = 1'b0;
               stage_next    = ST_PRECHARGE;
            end
         end
         ST_PRECHARGE: begin
            // R01 trickle current
            cur_next = CUR_PRECHARGE_MA;
            if (above_s) begin
               // R07 enter fast charge
               dead_run_next = 1'b0;
               cur_next      = CUR_PRECHARGE_MA;
               stage_next    = ST_FAST;
            end else if (dead_run_reg && dead_battery_timer_enable && dead_reg >= DEAD_TICKS) begin
               // R04 dead-battery shutdown
               dfault_next = 1'b1;
               cur_next    = 10'h0;
               stage_next  = ST_FAULT;
            end
         end
         ST_FAST: begin
            acc_next = classify(short_s, host_s, cport_s, id_s);
            // R09 soft start ramp
            if (tick) begin
               if (cur_reg + CUR_STEP_MA < target)
                  cur_next = cur_reg + CUR_STEP_MA;
               else
                  cur_next = target;
            end
            if (atreg_s)
               // R13 enter voltage regulation
               stage_next = ST_VREG;
         end
         ST_VREG: begin
            if (term_s) begin
               // R13 halt or top off at termination
               aux_next = 32'h0;
               if (topoff_enable) begin
                  stage_next = ST_TOPOFF;
               end else if (auto_stop) begin
                  // charger drops in the same cycle as the halt
                  cur_next   = 10'h0;
                  stage_next = ST_DONE;
               end
            end
         end
         ST_TOPOFF: begin
            if (tick)
               aux_next = aux_reg + 32'h1;
            if (aux_reg >= TOPOFF_TICKS && auto_stop) begin
               aux_next   = 32'h0;
               cur_next   = 10'h0;
               stage_next = ST_DONE;
            end
         end
         ST_DONE: begin
            cur_next = 10'h0;
            // R15 restart after debounced drop
            if (!below_s)
               aux_next = 32'h0;
            else if (tick)
               aux_next = aux_reg + 32'h1;
            if (below_s && aux_reg >= DEBOUNCE_TICKS) begin
               total_next = 32'h0;
               cur_next   = CUR_PRECHARGE_MA;
               stage_next = ST_FAST;
            end
         end
         ST_FAULT: begin
            cur_next = 10'h0;
            // R14 re-enable clears a timer overrun
            if (tfault_reg && charger_enable && !en_d_reg) begin
               tfault_next = 1'b0;
               total_next  = 32'h0;
               stage_next  = ST_PRECHARGE;
            end
         end
         default: stage_next = ST_IDLE;
      endcase

      // R14 total timer overrun
      if (total_charge_timer_enable && total_reg >= total_limit &&
          (stage_reg == ST_PRECHARGE || stage_reg == ST_FAST || stage_reg == ST_VREG)) begin
         tfault_next = 1'b1;
         cur_next    = 10'h0;
         stage_next  = ST_FAULT;
      end
      if (!charger_enable && stage_reg != ST_IDLE && stage_reg != ST_FAULT)
         cur_next = 10'h0;

      // R17 supply loss returns to idle
      if (!sv_s) begin
         stage_next    = ST_IDLE;
         dead_next     = 32'h0;
         total_next    = 32'h0;
         aux_next      = 32'h0;
         dead_run_next = 1'b0;
         cur_next      = 10'h0;
         acc_next      = ACC_NONE;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stage_reg    <= ST_IDLE;
         pre_reg      <= 32'h0;
         dead_reg     <= 32'h0;
         total_reg    <= 32'h0;
         aux_reg      <= 32'h0;
         dead_run_reg <= 1'b0;
         sv_d_reg     <= 1'b0;
         en_d_reg     <= 1'b0;
         cur_reg      <= 10'h0;
         acc_reg      <= ACC_NONE;
         dfault_reg   <= 1'b0;
         tfault_reg   <= 1'b0;
      end else begin
         stage_reg    <= stage_next;
         pre_reg      <= pre_next;
         dead_reg     <= dead_next;
         total_reg    <= total_next;
         aux_reg      <= aux_next;
         dead_run_reg <= dead_run_next;
         sv_d_reg     <= sv_d_next;
         en_d_reg     <= en_d_next;
         cur_reg      <= cur_next;
         acc_reg      <= acc_next;
         dfault_reg   <= dfault_next;
         tfault_reg   <= tfault_next;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // outputs
   assign charger_on          = (cur_reg != 10'h0);
   assign charge_current_ma   = cur_reg;
   assign voltage_loop_active = (stage_reg == ST_VREG) || (stage_reg == ST_TOPOFF);
   // R06 detection and bus held off in precharge
   assign detection_enable    = (stage_reg == ST_FAST) || (stage_reg == ST_VREG) ||
                                (stage_reg == ST_TOPOFF) || (stage_reg == ST_DONE);
   assign serial_bus_enable   = (stage_reg != ST_PRECHARGE);
   assign accessory_type      = acc_reg;
   assign charge_stage        = stage_reg;
   assign dead_battery_fault  = dfault_reg;
   assign total_timer_fault   = tfault_reg;

endmodule // battery_charge_sequencer
`default_nettype wire

/* File: verif/charge_seq_checker_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module charge_seq_checker
   import charge_seq_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       rst,
   input wire logic       supply_valid,
   input wire logic       charger_enable,
   input wire logic       charger_on,
   input wire logic [9:0] charge_current_ma,
   input wire logic       voltage_loop_active,
   input wire logic       detection_enable,
   input wire logic       serial_bus_enable,
   input wire logic [2:0] charge_stage,
   input wire logic       dead_battery_fault
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_trickle_level: // trickle current
      assert property ((charge_stage == 3'h1 && charger_enable)[*2]
         |-> charge_current_ma == CUR_PRECHARGE_MA) else $error("precharge current wrong");
   a_attach_start: // attach starts charging
      assert property ($rose(supply_valid) ##1 supply_valid[*3]
         |-> ##[0:1] charge_stage inside {3'h1, 3'h2}) else $error("attach not taken");
   a_dead_off: // dead battery shutdown
      assert property (dead_battery_fault |-> !charger_on && charge_current_ma == 10'h000)
         else $error("charger on after dead fault");
   a_prequal_quiet: // no detection in precharge
      assert property (charge_stage == 3'h1 |-> !detection_enable && !serial_bus_enable)
         else $error("detection active in precharge");
   a_soft_ramp: // bounded current step
      assert property (charge_stage == 3'h2 && $past(charge_stage) == 3'h2
         |-> charge_current_ma <= $past(charge_current_ma) + CUR_STEP_MA)
         else $error("current stepped too far");
   a_fast_detect: // detection in fast stage
      assert property (charge_stage == 3'h2 |-> detection_enable && !voltage_loop_active)
         else $error("fast stage outputs wrong");
   a_cv_loop: // voltage loop in regulation
      assert property (charge_stage == 3'h3 |-> voltage_loop_active)
         else $error("voltage loop off in regulation");
   a_loss_idle: // supply loss idles
      assert property (!supply_valid[*4] |-> ##[0:3] (charge_stage == 3'h0 && !charger_on))
         else $error("no idle after supply loss");
   a_enable_gate: // disabled charger off
      assert property (!charger_enable ##1 !charger_enable |-> charge_current_ma == 10'h000)
         else $error("current while disabled");

   c_fast_max: cover property (charge_stage == 3'h2 && charge_current_ma == 10'h3a2);
   c_dead: cover property ($rose(dead_battery_fault));
   c_regulate: cover property (charge_stage == 3'h3);
endmodule // charge_seq_checker
`default_nettype wire

/* File: verif/charge_source_battery_model.sv */
`timescale 1ns/1ps
`default_nettype none
module charge_source_battery_model
   import charge_seq_pkg::*;
#(
   parameter int PREQ_LVL = 20,
   parameter int REG_LVL  = 200
) (
   input  wire logic       clk_sys,
   input  wire logic       attach,
   input  wire logic [2:0] kind,
   input  wire logic       shorted,
   input  wire logic       stall,
   input  wire logic       charger_on,
   output logic            supply_valid,
   output logic            batt_above_prequal,
   output logic            batt_at_regulation,
   output logic            batt_below_restart,
   output logic            term_current_reached,
   output logic            connector_data_plus,
   output logic            connector_data_minus,
   output logic            data_lines_shorted,
   output logic            host_port_present,
   output logic            charging_port_signature,
   output logic [4:0]      accessory_id_line
);
   int   level = 0;
   logic flip  = 1'b0;

   always @(posedge clk_sys) begin
      flip <= ~flip;
      if (shorted)
         level <= 0;
      else if (charger_on && !stall)
         level <= level + 1;
   end
   ////////////////////////////////////////
   always_comb begin
      supply_valid            = attach;
      batt_above_prequal      = level > PREQ_LVL;
      batt_at_regulation      = level >= REG_LVL;
      term_current_reached    = level >= REG_LVL + 40;
      batt_below_restart      = level < REG_LVL - 15;
      data_lines_shorted      = attach && kind == ACC_DCP;
      host_port_present       = attach && (kind == ACC_SDP || kind == ACC_CDP);
      charging_port_signature = attach && kind == ACC_CDP;
      // released lines wander rather than hold
      connector_data_plus     = attach ? host_port_present : flip;
      connector_data_minus    = attach ? host_port_present : ~flip;
      accessory_id_line       = !attach ? 5'h1f : kind == ACC_CARKIT ? 5'h17 :
                                kind == ACC_TRAVEL ? 5'h16 : 5'h1f;
   end
endmodule // charge_source_battery_model
`default_nettype wire

/* File: verif/battery_charge_sequencer_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module battery_charge_sequencer_tb_top
   import charge_seq_pkg::*;
;
   logic       clk_sys, rst, supply_valid, batt_above_prequal, batt_at_regulation;
   logic       batt_below_restart, term_current_reached, connector_data_plus;
   logic       connector_data_minus, data_lines_shorted, host_port_present;
   logic       charging_port_signature, charger_enable, dead_battery_timer_enable;
   logic       total_charge_timer_enable, fast_charge_force, fast_charge_auto_select;
   logic       topoff_enable, auto_stop, charger_on, voltage_loop_active, detection_enable;
   logic       serial_bus_enable, dead_battery_fault, total_timer_fault, attach, shorted, stall;
   logic [1:0] total_charge_duration_select;
   logic [2:0] fast_charge_current_setting, accessory_type, charge_stage, kind;
   logic [4:0] accessory_id_line;
   logic [9:0] charge_current_ma;
   int         mismatches = 0, checked = 0, n;
   typedef struct packed {
      logic f; logic a; logic [2:0] s; logic [2:0] k; logic [9:0] cur;
   } row_t;
   row_t rows [8] = '{
      '{1'b0, 1'b1, 3'h3, ACC_DCP, 10'h1c2}, '{1'b0, 1'b1, 3'h3, ACC_CDP, 10'h1c2},
      '{1'b0, 1'b1, 3'h7, ACC_CARKIT, 10'h3a2}, '{1'b0, 1'b1, 3'h5, ACC_SDP, 10'h05a},
      '{1'b0, 1'b0, 3'h5, ACC_DCP, 10'h05a}, '{1'b1, 1'b0, 3'h0, ACC_SDP, 10'h05a},
      '{1'b1, 1'b0, 3'h2, ACC_TRAVEL, 10'h14a}, '{1'b0, 1'b1, 3'h1, ACC_NONE, 10'h05a}};

   battery_charge_sequencer #(.TICK_DIV(4), .DEAD_TICKS(10), .HOUR_TICKS(20),
      .TOPOFF_TICKS(10), .DEBOUNCE_TICKS(3)) uut (.*);
   charge_source_battery_model model (.*);

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////
   task automatic report_and_stop();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic check_bus(input logic [9:0] got, input logic [9:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask
   task automatic check_flag(input logic got, input logic exp, input string m);
      check_bus({9'h0, got}, {9'h0, exp}, m);
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge clk_sys);
   endtask
   // n counts cycles until stage or current reaches v
   task automatic wait_for(input logic cur, input logic [9:0] v, input int lim);
      n = 0;
      while ((cur ? charge_current_ma : {7'h0, charge_stage}) !== v) begin
         @(negedge clk_sys);
         n++;
         if (n > lim) begin
            mismatches++;
            $display("wrong value at %0t: wait for %h ran out", $time, v);
            report_and_stop();
         end
      end
   endtask
   ////////////////////////////////////////
   initial begin
      rst = 1'b1;
      attach = 1'b0;
      kind = ACC_DCP;
      shorted = 1'b1;
      stall = 1'b0;
      charger_enable = 1'b1;
      dead_battery_timer_enable = DBT_EN_RESET;
      total_charge_timer_enable = TCT_EN_RESET;
      total_charge_duration_select = TC_DURATION_RESET;
      fast_charge_current_setting = FC_SETTING_RESET;
      fast_charge_force = 1'b0;
      fast_charge_auto_select = 1'b1;
      topoff_enable = 1'b0;
      auto_stop = 1'b0;
      cyc(12);
      rst = 1'b0;
      cyc(2);
      check_flag(serial_bus_enable, 1'b1, "bus after reset");
      check_bus({7'h0, charge_stage}, 10'h000, "stage after reset");
      attach = 1'b1;
      wait_for(1'b0, 10'h001, 10);
      cyc(2);
      check_bus(charge_current_ma, 10'h05a, "trickle");
      check_flag(detection_enable | serial_bus_enable, 1'b0, "quiet");
      wait_for(1'b0, 10'h006, 60);
      check_flag(n inside {[30:50]}, 1'b1, "dead period");
      check_flag(dead_battery_fault & ~charger_on, 1'b1, "dead stop");
      attach = 1'b0;
      cyc(8);
      check_bus({7'h0, charge_stage}, 10'h000, "idle");
      attach = 1'b1;
      wait_for(1'b0, 10'h001, 10);
      check_flag(dead_battery_fault, 1'b0, "fault cleared");
      wait_for(1'b0, 10'h006, 60);
      check_flag(n > 34, 1'b1, "fresh period");
      attach = 1'b0;
      dead_battery_timer_enable = 1'b0;
      cyc(8);
      attach = 1'b1;
      cyc(100);
      check_bus({7'h0, charge_stage}, 10'h001, "timer off");
      shorted = 1'b0;
      dead_battery_timer_enable = 1'b1;
      wait_for(1'b0, 10'h002, 60);
      stall = 1'b1;
      foreach (rows[i]) begin
         attach = 1'b0;
         fast_charge_force = rows[i].f;
         fast_charge_auto_select = rows[i].a;
         fast_charge_current_setting = rows[i].s;
         kind = rows[i].k;
         cyc(8);
         attach = 1'b1;
         wait_for(1'b0, 10'h002, 20);
         wait_for(1'b1, rows[i].cur, 200);
         cyc(16);
         check_bus(charge_current_ma, rows[i].cur, "fast current");
         check_bus({7'h0, accessory_type}, {7'h0, rows[i].k}, "accessory");
      end
      attach = 1'b0;
      total_charge_duration_select = 2'h1;
      cyc(8);
      attach = 1'b1;
      wait_for(1'b0, 10'h006, 600);
      check_flag(n inside {[470:500]}, 1'b1, "total period");
      check_flag(total_timer_fault & ~charger_on, 1'b1, "timer stop");
      charger_enable = 1'b0;
      cyc(2);
      charger_enable = 1'b1;
      wait_for(1'b0, 10'h002, 20);
      check_flag(total_timer_fault, 1'b0, "timer cleared");
      stall = 1'b0;
      wait_for(1'b0, 10'h003, 300);
      cyc(100);
      check_bus({7'h0, charge_stage}, 10'h003, "cv kept");
      auto_stop = 1'b1;
      wait_for(1'b0, 10'h005, 40);
      check_flag(charger_on, 1'b0, "halted");
      report_and_stop();
   end
endmodule // battery_charge_sequencer_tb_top
bind battery_charge_sequencer charge_seq_checker chk (.*);
`default_nettype wire
